/* pll_ctrl_pkg.sv */
// Package for the PLL clock generator control block: register map, fields, resets, types
package pll_ctrl_pkg;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] LOOP_CONTROL_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] BANDWIDTH_CTRL_OFF = 4'h4;
  localparam logic [ADDR_W-1:0] LOOP_PROGRAM_OFF = 4'h8;

  // Control register fields
  localparam int CTL_IRQ_EN_BIT = 7;
  localparam int CTL_FLAG_BIT = 6;
  localparam int CTL_PWR_BIT = 5;
  localparam int CTL_SEL_BIT = 4;
  localparam logic [3:0] CTL_UNUSED_RD = 4'hF;

  // Bandwidth register fields
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_LOCK_BIT = 6;
  localparam int BW_TRK_BIT = 5;
  localparam int BW_XLOSS_BIT = 4;

  // Reset values
  localparam logic [3:0] MUL_RESET = 4'h6;
  localparam logic [3:0] VRS_RESET = 4'h6;
  localparam logic PWR_RESET = 1'b1;

  // Crystal-loss check window is N * 4 VCO cycles
  localparam int XLOSS_FACTOR = 4;
  localparam int XCNT_W = 8;
  // Settling windows of the lock detector, in crystal edges
  localparam int ACQ_SETTLE = 16;
  localparam int LOCK_SETTLE = 32;
  localparam int SETTLE_W = 6;
  // Source switch holds output until three cycles of each source have passed
  localparam int SWITCH_CYCLES = 3;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef struct packed {
    logic irq_en;
    logic flag;
    logic power_on;
    logic select;
  } loop_ctl_s;

  typedef struct packed {
    logic [3:0] mul;
    logic [3:0] vrs;
  } loop_prog_s;

  typedef enum logic [1:0] {
    SW_XTAL = 2'b00,
    SW_HOLD_TO_VCO = 2'b01,
    SW_VCO = 2'b11,
    SW_HOLD_TO_XTAL = 2'b10
  } switch_e;

endpackage

/* pll_clock_gen_control.sv */
// PLL clock generator control: registers, loss/lock status, source selection, stop handling
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module pll_clock_gen_control #(
  parameter int MUL_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pll_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pll_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_enable_in,
  input wire logic break_active,
  input wire logic break_clear_enable,
  input wire logic crystal_tick,
  input wire logic vco_tick,
  input wire logic freq_in_track_tol,
  input wire logic freq_in_lock_tol,
  output logic crystal_clock,
  output logic base_clock_out,
  output logic loop_irq_out,
  output logic vco_enable,
  output logic [MUL_W-1:0] feedback_divide_ratio,
  output logic [3:0] vco_center_range
);
  import pll_ctrl_pkg::*;

  loop_ctl_s ctl_q;
  loop_prog_s prog_q;
  logic auto_q;
  logic lock_q;
  logic trk_q;
  logic manual_trk_q;
  logic xloss_q;
  logic [XCNT_W-1:0] xcnt_q;
  logic xarm_q;
  logic [SETTLE_W-1:0] settle_q;
  switch_e sw_q;
  logic [1:0] xsw_cnt_q;
  logic [1:0] vsw_cnt_q;
  logic src_vco_q;
  logic div_q;

  // AXI4-Lite slave: address and data taken in either order
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wbyte;

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wbyte = wdata_q[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end
    end
  end

  logic wr_ctl;
  logic wr_bw;
  logic wr_prog;
  logic addr_ok_w;
  assign wr_ctl = wr_fire && wstrb_q[0] && awaddr_q == LOOP_CONTROL_OFF;
  assign wr_bw = wr_fire && wstrb_q[0] && awaddr_q == BANDWIDTH_CTRL_OFF;
  assign wr_prog = wr_fire && wstrb_q[0] && awaddr_q == LOOP_PROGRAM_OFF;
  assign addr_ok_w = awaddr_q == LOOP_CONTROL_OFF || awaddr_q == BANDWIDTH_CTRL_OFF
    || awaddr_q == LOOP_PROGRAM_OFF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok_w ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path; reading the control register is the flag clear
  logic rd_ctl;
  logic [7:0] ctl_rd;
  logic [7:0] bw_rd;
  assign rd_ctl = rd_fire && s_axi_araddr == LOOP_CONTROL_OFF;
  assign ctl_rd = {ctl_q.irq_en && auto_q, ctl_q.flag && auto_q, ctl_q.power_on,
                   ctl_q.select, CTL_UNUSED_RD};
  assign bw_rd = {auto_q, lock_q && auto_q, auto_q ? trk_q : manual_trk_q,
                  xloss_q && ctl_q.select, 4'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= AXI_OKAY;
        unique case (s_axi_araddr)
          LOOP_CONTROL_OFF: s_axi_rdata <= {24'h0, ctl_rd};
          BANDWIDTH_CTRL_OFF: s_axi_rdata <= {24'h0, bw_rd};
          LOOP_PROGRAM_OFF: s_axi_rdata <= {24'h0, prog_q.mul, prog_q.vrs};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready && s_axi_rvalid) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Lock change detection
  logic lock_next;
  logic lock_change;
  logic flag_clr;
  assign lock_change = auto_q && (lock_next != lock_q);
  // In break with clearing disabled, accesses leave the flag alone
  assign flag_clr = rd_ctl && (!break_active || break_clear_enable);
  logic stopped;
  assign stopped = !osc_enable_in;

  // Control register; a wait state has no input here, so it changes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= '{irq_en: 1'b0, flag: 1'b0, power_on: PWR_RESET, select: 1'b0};
    end else begin
      if (wr_ctl) begin
        if (auto_q) begin
          ctl_q.irq_en <= wbyte[CTL_IRQ_EN_BIT];
        end
        // Power-on stays while VCO selected; select needs power-on and nonzero range
        if (wbyte[CTL_PWR_BIT] || ctl_q.select && wbyte[CTL_SEL_BIT]) begin
          ctl_q.power_on <= 1'b1;
        end else if (!ctl_q.select) begin
          ctl_q.power_on <= 1'b0;
        end
        // Lock state is deliberately not checked here
        ctl_q.select <= wbyte[CTL_SEL_BIT] && ctl_q.power_on && prog_q.vrs != 4'h0;
      end
      if (prog_q.vrs == 4'h0 || stopped) begin
        ctl_q.select <= 1'b0;
      end
      // Set wins over a simultaneous clear
      if (lock_change) begin
        ctl_q.flag <= 1'b1;
      end else if (flag_clr || !auto_q) begin
        ctl_q.flag <= 1'b0;
      end
    end
  end

  // Programming register, locked while the loop is powered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_q <= '{mul: MUL_RESET, vrs: VRS_RESET};
    end else if (wr_prog && !ctl_q.power_on) begin
      prog_q <= wbyte;
    end
  end

  // Bandwidth register; reserved low bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_q <= 1'b0;
      manual_trk_q <= 1'b0;
    end else if (wr_bw) begin
      auto_q <= wbyte[BW_AUTO_BIT];
      if (!auto_q) begin
        manual_trk_q <= wbyte[BW_TRK_BIT];
      end
    end
  end

  // Crystal loss: write one arms, crystal ticks during N*4 window clear it
  logic [MUL_W-1:0] n_eff;
  assign n_eff = (prog_q.mul == 4'h0) ? MUL_W'(1) : MUL_W'(prog_q.mul);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xloss_q <= 1'b0;
      xarm_q <= 1'b0;
      xcnt_q <= '0;
    end else if (!ctl_q.select || stopped) begin
      xloss_q <= 1'b0;
      xarm_q <= 1'b0;
    end else if (wr_bw && wbyte[BW_XLOSS_BIT]) begin
      xloss_q <= 1'b1;
      xarm_q <= 1'b1;
      xcnt_q <= '0;
    end else if (xarm_q) begin
      if (crystal_tick) begin
        xloss_q <= 1'b0;
        xarm_q <= 1'b0;
      end else if (vco_tick) begin
        xcnt_q <= xcnt_q + XCNT_W'(1);
        if (xcnt_q >= XCNT_W'(n_eff * XLOSS_FACTOR)) begin
          xarm_q <= 1'b0;
        end
      end
    end
  end

  // Tracking and lock status from frequency-tolerance inputs
  logic loop_run;
  assign loop_run = ctl_q.power_on && prog_q.vrs != 4'h0 && !stopped;
  assign lock_next = loop_run && auto_q && trk_q && freq_in_lock_tol
    && settle_q >= SETTLE_W'(LOCK_SETTLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trk_q <= 1'b0;
      lock_q <= 1'b0;
      settle_q <= '0;
    end else begin
      lock_q <= lock_next;
      if (!loop_run || !auto_q || !freq_in_track_tol) begin
        trk_q <= 1'b0;
        settle_q <= '0;
      end else if (crystal_tick) begin
        if (settle_q != '1) begin
          settle_q <= settle_q + SETTLE_W'(1);
        end
        if (settle_q >= SETTLE_W'(ACQ_SETTLE)) begin
          trk_q <= 1'b1;
        end
      end
    end
  end

  // Glitch-free source switch: output frozen during hand-over
  logic want_vco;
  assign want_vco = ctl_q.select;

  always_ff @(posedge aclk) begin
    if (!aresetn || stopped) begin
      sw_q <= SW_XTAL;
      src_vco_q <= 1'b0;
      xsw_cnt_q <= '0;
      vsw_cnt_q <= '0;
    end else begin
      unique case (sw_q)
        SW_XTAL: if (want_vco) begin
          sw_q <= SW_HOLD_TO_VCO;
          xsw_cnt_q <= '0;
          vsw_cnt_q <= '0;
        end
        SW_VCO: if (!want_vco) begin
          sw_q <= SW_HOLD_TO_XTAL;
          xsw_cnt_q <= '0;
          vsw_cnt_q <= '0;
        end
        SW_HOLD_TO_VCO, SW_HOLD_TO_XTAL: begin
          if (crystal_tick && xsw_cnt_q != 2'(SWITCH_CYCLES)) begin
            xsw_cnt_q <= xsw_cnt_q + 2'd1;
          end
          if (vco_tick && vsw_cnt_q != 2'(SWITCH_CYCLES)) begin
            vsw_cnt_q <= vsw_cnt_q + 2'd1;
          end
          if (xsw_cnt_q == 2'(SWITCH_CYCLES) && vsw_cnt_q == 2'(SWITCH_CYCLES)) begin
            src_vco_q <= (sw_q == SW_HOLD_TO_VCO);
            sw_q <= (sw_q == SW_HOLD_TO_VCO) ? SW_VCO : SW_XTAL;
          end
        end
      endcase
    end
  end

  // Divide-by-two base clock; held while switching, cleared while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || stopped) begin
      div_q <= 1'b0;
    end else if (sw_q == SW_XTAL || sw_q == SW_VCO) begin
      if (src_vco_q ? vco_tick : crystal_tick) begin
        div_q <= !div_q;
      end
    end
  end

  // Registered outputs; clocks, request and VCO enable forced low while the oscillator is disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_clock <= 1'b0;
      base_clock_out <= 1'b0;
      loop_irq_out <= 1'b0;
      vco_enable <= 1'b0;
      feedback_divide_ratio <= MUL_W'(MUL_RESET);
      vco_center_range <= VRS_RESET;
    end else begin
      crystal_clock <= osc_enable_in && crystal_tick;
      base_clock_out <= osc_enable_in && div_q;
      loop_irq_out <= osc_enable_in && auto_q && ctl_q.irq_en && ctl_q.flag;
      vco_enable <= loop_run;
      feedback_divide_ratio <= n_eff;
      vco_center_range <= prog_q.vrs;
    end
  end

endmodule

/* pll_clock_gen_control_properties.sv */
// Port checks of the PLL clock generator control block
`timescale 1ns/100ps
module pll_clock_gen_control_properties #(
  parameter int MUL_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic osc_enable_in,
  input wire logic crystal_clock,
  input wire logic base_clock_out,
  input wire logic loop_irq_out,
  input wire logic vco_enable,
  input wire logic [MUL_W-1:0] feedback_divide_ratio,
  input wire logic [3:0] vco_center_range
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_stop_outputs_low: assert property (!osc_enable_in ##1 !osc_enable_in |->
    !crystal_clock && !base_clock_out && !loop_irq_out) else $error("stop outputs high");
  a_stop_vco_off: assert property (!osc_enable_in ##1 !osc_enable_in |->
    !vco_enable) else $error("vco on in stop");
  a_ratio_nonzero: assert property (feedback_divide_ratio != 4'h0)
    else $error("ratio zero");
  a_range_zero_off: assert property (vco_center_range == 4'h0 ##1
    vco_center_range == 4'h0 |-> !vco_enable) else $error("vco on at range zero");
  // Two powered samples bracket the write edge whatever the enable latency
  a_prog_frozen_on: assert property (vco_enable && $past(vco_enable) |->
    $stable(feedback_divide_ratio) && $stable(vco_center_range)) else $error("prog changed");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property (loop_irq_out);
  c_stop: cover property (!osc_enable_in ##1 !osc_enable_in);
endmodule

bind pll_clock_gen_control pll_clock_gen_control_properties #(.MUL_W(MUL_W))
  pll_clock_gen_control_properties_inst (
  .aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .s_axi_bready, .osc_enable_in, .crystal_clock, .base_clock_out, .loop_irq_out,
  .vco_enable, .feedback_divide_ratio, .vco_center_range
);

/* pll_clock_src_model.sv */
// Crystal, VCO and loop error model feeding the control block
`timescale 1ns/100ps
module pll_clock_src_model (
  input wire logic aclk,
  input wire logic osc_enable_in,
  input wire logic xtal_alive,
  input wire logic vco_enable,
  input wire logic lock_cmd,
  output logic crystal_tick = 1'b0,
  output logic vco_tick = 1'b0,
  output logic freq_in_track_tol = 1'b0,
  output logic freq_in_lock_tol = 1'b0
);
  logic [1:0] div_q = 2'h0;
  always_ff @(posedge aclk) begin
    div_q <= div_q + 2'h1;
    // A dead or stopped crystal gives no edges at all
    crystal_tick <= xtal_alive && osc_enable_in && (div_q == 2'h0);
    vco_tick <= vco_enable && div_q[0];
    // Lock tolerance never holds without tracking tolerance
    freq_in_track_tol <= lock_cmd && vco_enable;
    freq_in_lock_tol <= lock_cmd && vco_enable;
  end
endmodule

/* pll_clock_gen_control_tb.sv */
// Self-checking bench of the PLL clock generator control block
`timescale 1ns/100ps
module pll_clock_gen_control_tb;
  import pll_ctrl_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, osc_enable_in = 1'b1, xtal_alive = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, lock_cmd = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, break_active = 1'b0;
  logic break_clear_enable = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic crystal_tick, vco_tick, freq_in_track_tol, freq_in_lock_tol, vco_enable;
  logic crystal_clock, base_clock_out, loop_irq_out;
  logic [3:0] feedback_divide_ratio, vco_center_range;
  int n_fail = 0, cmp_count = 0;
  pll_clock_gen_control pll_clock_gen_control_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .osc_enable_in, .break_active, .break_clear_enable,
    .crystal_tick, .vco_tick, .freq_in_track_tol, .freq_in_lock_tol, .crystal_clock,
    .base_clock_out, .loop_irq_out, .vco_enable, .feedback_divide_ratio, .vco_center_range
  );
  pll_clock_src_model pll_clock_src_model_inst (
    .aclk, .osc_enable_in, .xtal_alive, .vco_enable, .lock_cmd, .crystal_tick, .vco_tick,
    .freq_in_track_tol, .freq_in_lock_tol
  );
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    n_fail++;
    report_and_stop();
  endtask
  // Each bus task opens on a fresh edge so no strobe is driven twice in one step
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (64) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, (a == 4'hC) ? AXI_SLVERR : AXI_OKAY});
        return;
      end
    end
    timed_out();
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (64) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk({rd[29:0], rsp}, {22'h0, e, (a == 4'hC) ? AXI_SLVERR : AXI_OKAY});
        return;
      end
    end
    timed_out();
  endtask
  task automatic t_reset_values();
    rd_chk(LOOP_PROGRAM_OFF, 8'h66);
    rd_chk(LOOP_CONTROL_OFF, 8'h2F);
    rd_chk(BANDWIDTH_CTRL_OFF, 8'h00);
    rd_chk(4'hC, 8'h00);
    axi_wr(4'hC, 8'h00);
    // Byte 0 not enabled, so the write must leave the register alone
    s_axi_wstrb <= 4'hE;
    axi_wr(BANDWIDTH_CTRL_OFF, 8'h20);
    s_axi_wstrb <= 4'hF;
    rd_chk(BANDWIDTH_CTRL_OFF, 8'h00);
    axi_wr(BANDWIDTH_CTRL_OFF, 8'h20);
    rd_chk(BANDWIDTH_CTRL_OFF, 8'h20);
  endtask
  task automatic t_program();
    axi_wr(LOOP_PROGRAM_OFF, 8'h35);
    rd_chk(LOOP_PROGRAM_OFF, 8'h66);
    axi_wr(LOOP_CONTROL_OFF, 8'h00);
    axi_wr(LOOP_PROGRAM_OFF, 8'h00);
    axi_wr(LOOP_CONTROL_OFF, 8'h20);
    axi_wr(LOOP_CONTROL_OFF, 8'h30);
    rd_chk(LOOP_CONTROL_OFF, 8'h2F);
    chk({28'h0, feedback_divide_ratio}, 32'h1);
    chk({27'h0, vco_enable, vco_center_range}, 32'h0);
    axi_wr(LOOP_CONTROL_OFF, 8'h00);
    axi_wr(LOOP_PROGRAM_OFF, 8'h03);
    rd_chk(LOOP_PROGRAM_OFF, 8'h03);
    chk({27'h0, vco_enable, vco_center_range}, 32'h3);
  endtask
  task automatic t_select();
    int i;
    axi_wr(LOOP_CONTROL_OFF, 8'h10);
    rd_chk(LOOP_CONTROL_OFF, 8'h0F);
    axi_wr(LOOP_CONTROL_OFF, 8'h20);
    axi_wr(LOOP_CONTROL_OFF, 8'h30);
    axi_wr(LOOP_CONTROL_OFF, 8'h10);
    rd_chk(LOOP_CONTROL_OFF, 8'h3F);
    xtal_alive <= 1'b0;
    axi_wr(BANDWIDTH_CTRL_OFF, 8'h10);
    repeat (40) @(posedge aclk);
    rd_chk(BANDWIDTH_CTRL_OFF, 8'h10);
    xtal_alive <= 1'b1;
    axi_wr(BANDWIDTH_CTRL_OFF, 8'h10);
    repeat (40) @(posedge aclk);
    rd_chk(BANDWIDTH_CTRL_OFF, 8'h00);
    osc_enable_in <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({29'h0, crystal_clock, base_clock_out, loop_irq_out}, 32'h0);
    osc_enable_in <= 1'b1;
    rd_chk(LOOP_CONTROL_OFF, 8'h2F);
    // After recovery both clock outputs must run again from the crystal
    for (i = 0; i < 32 && crystal_clock !== 1'b1; i++) @(posedge aclk);
    if (i == 32) timed_out();
    chk({31'h0, crystal_clock}, 32'h1);
    for (i = 0; i < 32 && base_clock_out !== 1'b1; i++) @(posedge aclk);
    if (i == 32) timed_out();
    chk({31'h0, base_clock_out}, 32'h1);
  endtask
  task automatic t_irq();
    int i;
    axi_wr(BANDWIDTH_CTRL_OFF, 8'h80);
    axi_wr(LOOP_CONTROL_OFF, 8'hA0);
    lock_cmd <= 1'b1;
    for (i = 0; i < 1000 && loop_irq_out !== 1'b1; i++) @(posedge aclk);
    if (i == 1000) timed_out();
    rd_chk(BANDWIDTH_CTRL_OFF, 8'hE0);
    // Lock confirmed above, only now hand the output to the loop
    axi_wr(LOOP_CONTROL_OFF, 8'hB0);
    break_active <= 1'b1;
    rd_chk(LOOP_CONTROL_OFF, 8'hFF);
    repeat (2) @(posedge aclk);
    chk({31'h0, loop_irq_out}, 32'h1);
    break_clear_enable <= 1'b1;
    rd_chk(LOOP_CONTROL_OFF, 8'hFF);
    break_active <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, loop_irq_out}, 32'h0);
    rd_chk(LOOP_CONTROL_OFF, 8'hBF);
    // Lock exit with the enable off: flag still sets, no request
    axi_wr(LOOP_CONTROL_OFF, 8'h30);
    lock_cmd <= 1'b0;
    repeat (20) @(posedge aclk);
    chk({31'h0, loop_irq_out}, 32'h0);
    rd_chk(BANDWIDTH_CTRL_OFF, 8'h80);
    rd_chk(LOOP_CONTROL_OFF, 8'h7F);
    axi_wr(BANDWIDTH_CTRL_OFF, 8'h00);
    repeat (20) @(posedge aclk);
    chk({31'h0, loop_irq_out}, 32'h0);
    rd_chk(LOOP_CONTROL_OFF, 8'h3F);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_program();
    t_select();
    t_irq();
    report_and_stop();
  end
endmodule
